/* hw/priority_interrupt_controller.sv */
// Two-level priority interrupt controller with AXI4-Lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module priority_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  ext_pin_in,
  input  wire logic [3:0]  upper_port_pins,
  input  wire logic        port_read,
  input  wire logic        timer0_overflow,
  input  wire logic        periph_high_req,
  input  wire logic        periph_low_req,
  input  wire logic        instr_boundary,
  input  wire logic [20:0] return_addr,
  input  wire logic        return_from_handler_instr,
  output vector_req_type   vector_req,
  output logic             push_return,
  output logic [20:0]      push_addr,
  output logic             pullup_disable,
  output logic [1:0]       active_level
);

  // Registers
  logic [7:0]  gctl_ff;
  logic [7:0]  eprio_ff;
  logic [7:0]  pctl_ff;
  logic        priority_mode_enable_ff;
  logic [3:0]  pin_s1_ff;
  logic [3:0]  pin_s2_ff;
  logic [3:0]  pin_s3_ff;
  logic [3:0]  port_s1_ff;
  logic [3:0]  port_s2_ff;
  logic [3:0]  port_latch_ff;
  logic        pc_mis_ff;
  logic [1:0]  pend_cnt_ff;
  logic        in_high_ff;
  logic        in_low_ff;
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [3:0]  aw_addr_ff;
  logic [7:0]  w_data_ff;
  logic        w_lane_ff;
  logic        bvalid_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  bresp_ff;
  logic [1:0]  rresp_ff;
  logic        take_ff;
  logic [20:0] vec_ff;
  logic        lvl_ff;
  logic [20:0] push_addr_ff;

  // Bus write path decode
  wire       aw_ok    = aw_hold_ff | awvalid;
  wire       w_ok     = w_hold_ff | wvalid;
  wire [3:0] wr_addr  = aw_hold_ff ? aw_addr_ff : awaddr;
  wire [7:0] wr_byte  = w_hold_ff ? w_data_ff : wdata[7:0];
  wire       wr_lane  = w_hold_ff ? w_lane_ff : wstrb[0];
  wire       wr_fire  = aw_ok & w_ok & ~bvalid_ff;
  wire       wr_en    = wr_fire & wr_lane;
  wire       wr_gctl  = wr_en & (wr_addr == global_irq_control_off);
  wire       wr_eprio = wr_en & (wr_addr == edge_priority_control_off);
  wire       wr_pctl  = wr_en & (wr_addr == ext_pin_irq_control_off);
  wire       wr_mode  = wr_en & (wr_addr == mode_control_off);
  wire       wr_map   = (wr_addr == global_irq_control_off) | (wr_addr == edge_priority_control_off) |
                        (wr_addr == ext_pin_irq_control_off) | (wr_addr == mode_control_off);
  assign awready = ~aw_hold_ff & ~bvalid_ff;
  assign wready  = ~w_hold_ff & ~bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  // Bus read path decode
  wire rd_fire = arvalid & ~rvalid_ff;
  wire rd_map  = (araddr == global_irq_control_off) | (araddr == edge_priority_control_off) |
                 (araddr == ext_pin_irq_control_off) | (araddr == mode_control_off);
  wire [7:0] rd_byte = (araddr == global_irq_control_off)    ? gctl_ff :
                       (araddr == edge_priority_control_off) ? eprio_ff :
                       (araddr == ext_pin_irq_control_off)   ? pctl_ff :
                       (araddr == mode_control_off)          ? {priority_mode_enable_ff, 5'h00, active_level} :
                                                               8'h00;
  assign arready = ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  // Edge detection on synchronised pins, edge polarity per select bit
  wire [3:0] edge_sel = {eprio_ff[edg3_bit], eprio_ff[edg2_bit], eprio_ff[edg1_bit], eprio_ff[edg0_bit]};
  wire [3:0] rise     = pin_s2_ff & ~pin_s3_ff;
  wire [3:0] fall     = ~pin_s2_ff & pin_s3_ff;
  wire [3:0] pin_evt  = (edge_sel & rise) | (~edge_sel & fall);
  wire       pc_evt   = |(port_s2_ff ^ port_latch_ff);

  // Flag updates: software write, hardware set wins
  wire [7:0] gctl_sw  = wr_gctl ? wr_byte : gctl_ff;
  wire [7:0] pctl_sw  = wr_pctl ? wr_byte : pctl_ff;
  wire [7:0] gctl_set = {5'h00, timer0_overflow, pin_evt[0], pc_evt};
  wire [7:0] pctl_set = {5'h00, pin_evt[3], pin_evt[2], pin_evt[1]};

  // Level requests
  wire pme    = priority_mode_enable_ff;
  wire glb_en = gctl_ff[glb_en_bit];
  wire grp_en = gctl_ff[grp_en_bit];
  wire r_t0   = gctl_ff[t0if_bit] & gctl_ff[t0ie_bit];
  wire r_p0   = gctl_ff[p0if_bit] & gctl_ff[p0ie_bit];
  wire r_pc   = gctl_ff[pcif_bit] & gctl_ff[pcie_bit];
  wire r_p1   = pctl_ff[p1if_bit] & pctl_ff[p1ie_bit];
  wire r_p2   = pctl_ff[p2if_bit] & pctl_ff[p2ie_bit];
  wire r_p3   = pctl_ff[p3if_bit] & pctl_ff[p3ie_bit];
  wire [5:0] core_req = {r_p3, r_p2, r_p1, r_pc, r_p0, r_t0};
  wire [5:0] core_pri = {eprio_ff[p3ip_bit], pctl_ff[p2ip_bit], pctl_ff[p1ip_bit],
                         eprio_ff[pcip_bit], 1'b1, eprio_ff[t0ip_bit]};
  wire hi_any = (|(core_req & core_pri)) | periph_high_req;
  wire lo_any = (|(core_req & ~core_pri)) | periph_low_req;
  wire compat_req = glb_en & ((|core_req) | (grp_en & (periph_high_req | periph_low_req)));
  wire pm_high    = glb_en & hi_any;
  wire pm_low     = pme & glb_en & grp_en & lo_any & ~in_low_ff & ~in_high_ff;
  wire want_high  = pme ? pm_high : compat_req;
  wire want       = want_high | pm_low;
  // A lasting port mismatch restarts the delay only when it appears, else it would stall entry
  wire pin_pend   = (|pin_evt) | (pc_evt & ~pc_mis_ff);

  // Entry waits a fixed delay after a pin or port-change event, and happens at an instruction boundary
  wire delay_done = (pend_cnt_ff == 2'h0);
  wire accept     = want & delay_done & instr_boundary & ~take_ff;
  wire acc_high   = accept & want_high;
  wire acc_low    = accept & ~want_high;

  // Global and low enable clearing on entry, setting on return
  wire ret_high = return_from_handler_instr & in_high_ff;
  wire ret_low  = return_from_handler_instr & ~in_high_ff & in_low_ff;
  wire ret_compat = return_from_handler_instr & ~pme;
  wire nxt_glb_en = acc_high ? 1'b0 : ((ret_high | ret_compat) ? 1'b1 : gctl_sw[glb_en_bit]);
  wire nxt_grp_en = (pme & acc_low) ? 1'b0 : ((pme & ret_low) ? 1'b1 : gctl_sw[grp_en_bit]);
  wire [7:0] nxt_gctl = {nxt_glb_en, nxt_grp_en, gctl_sw[5:0] | gctl_set[5:0]};
  wire [7:0] nxt_pctl = pctl_sw | pctl_set;
  wire [1:0] nxt_pend = pin_pend ? entry_delay : (delay_done ? 2'h0 : pend_cnt_ff - 2'h1);

  assign pullup_disable = eprio_ff[pud_bit];
  assign active_level   = {in_high_ff, in_low_ff};
  assign vector_req     = '{take: take_ff, vector: vec_ff, high_level: lvl_ff};
  assign push_return    = take_ff;
  assign push_addr      = push_addr_ff;

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gctl_ff <= global_irq_control_rst;
      eprio_ff <= edge_priority_control_rst;
      pctl_ff <= ext_pin_irq_control_rst;
      priority_mode_enable_ff <= 1'b0;
    end else begin
      gctl_ff <= nxt_gctl;
      pctl_ff <= nxt_pctl;
      if (wr_eprio) eprio_ff <= wr_byte;
      if (wr_mode) priority_mode_enable_ff <= wr_byte[7];
    end
  end

  // Pin synchronisers and port-change reference latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      pin_s3_ff <= 4'h0;
      port_s1_ff <= 4'h0;
      port_s2_ff <= 4'h0;
      port_latch_ff <= 4'h0;
      pc_mis_ff <= 1'b0;
      pend_cnt_ff <= 2'h0;
    end else begin
      pin_s1_ff <= ext_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      port_s1_ff <= upper_port_pins;
      port_s2_ff <= port_s1_ff;
      if (port_read) port_latch_ff <= port_s2_ff;
      pc_mis_ff <= pc_evt;
      pend_cnt_ff <= nxt_pend;
    end
  end

  // Handler level tracking and vector output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_high_ff <= 1'b0;
      in_low_ff <= 1'b0;
      take_ff <= 1'b0;
      vec_ff <= high_vector;
      lvl_ff <= 1'b0;
      push_addr_ff <= 21'h000000;
    end else begin
      take_ff <= accept;
      if (accept) begin
        vec_ff <= (pme & acc_low) ? low_vector : high_vector;
        lvl_ff <= acc_high;
        push_addr_ff <= return_addr;
      end
      if (acc_high) in_high_ff <= 1'b1;
      else if (ret_high) in_high_ff <= 1'b0;
      if (acc_low) in_low_ff <= 1'b1;
      else if (ret_low | (return_from_handler_instr & ~pme)) in_low_ff <= 1'b0;
    end
  end

  // Bus slave state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end else begin
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? 2'h0 : 2'h2;
      end else begin
        if (awvalid & awready) begin
          aw_hold_ff <= 1'b1;
          aw_addr_ff <= awaddr;
        end
        if (wvalid & wready) begin
          w_hold_ff <= 1'b1;
          w_data_ff <= wdata[7:0];
          w_lane_ff <= wstrb[0];
        end
        if (bvalid_ff & bready) bvalid_ff <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h000000, rd_byte};
        rresp_ff <= rd_map ? 2'h0 : 2'h2;
      end else if (rvalid_ff & rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Vector selection and stack push on entry
  low_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_low |=> vector_req.take && vector_req.vector == low_vector)
    else $error("low vector wrong");
  high_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_high |=> vector_req.vector == high_vector)
    else $error("high vector wrong");
  compat_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pme && accept) |=> vector_req.vector == high_vector)
    else $error("compat vector wrong");
  push_a: assert property (@(posedge aclk) disable iff (!aresetn)
    accept |=> push_return && push_addr == $past(return_addr))
    else $error("push missing");
  take_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_req.take |=> !vector_req.take)
    else $error("take longer than one cycle");

  // Level arbitration and global gating
  no_low_in_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_high_ff |-> !acc_low)
    else $error("low preempted high");
  high_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_high |=> vector_req.high_level && in_high_ff)
    else $error("high level not marked");
  glb_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !glb_en |-> !accept)
    else $error("accepted with global enable clear");
  low_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_low |-> pme && grp_en)
    else $error("low entry without low enable");
  pin0_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pme && accept && gctl_ff[p0if_bit] && gctl_ff[p0ie_bit]) |-> acc_high)
    else $error("pin 0 not taken as high");
  compat_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pme && accept) |-> acc_high)
    else $error("compat entry not high");
  periph_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pme && !grp_en && !(|core_req)) |-> !accept)
    else $error("peripheral passed without group enable");
  entry_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_pend |=> !accept)
    else $error("entry too soon after pin event");

  // Global and low enable clearing, global enable restoring
  clr_glb_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_high |=> !gctl_ff[glb_en_bit])
    else $error("global enable not cleared");
  clr_grp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pme && acc_low) |=> !gctl_ff[grp_en_bit])
    else $error("low enable not cleared");
  ret_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ret_high |=> gctl_ff[glb_en_bit])
    else $error("return did not re-enable");

  // Flag setting from events
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timer0_overflow |=> gctl_ff[t0if_bit])
    else $error("timer flag lost");
  pin_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pin_s2_ff[1]) && eprio_ff[edg1_bit] |=> pctl_ff[p1if_bit])
    else $error("pin1 flag lost");
  fall_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pin_s2_ff[0]) && !eprio_ff[edg0_bit] |=> gctl_ff[p0if_bit])
    else $error("pin0 falling flag lost");
  pin3_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pin_s2_ff[3]) && eprio_ff[edg3_bit] |=> pctl_ff[p3if_bit])
    else $error("pin3 flag lost");
  port_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_evt |=> gctl_ff[pcif_bit])
    else $error("port change flag lost");

  // Register bus answers
  slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !wr_map) |=> bvalid && bresp == 2'h2)
    else $error("unmapped write not refused");
  rd_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read upper bits not zero");
  pullup_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_eprio |=> pullup_disable == $past(wr_byte[pud_bit]))
    else $error("pull-up control not written");

  // Main scenarios reached
  cov_high_c: cover property (@(posedge aclk) disable iff (!aresetn) acc_high);
  cov_low_c: cover property (@(posedge aclk) disable iff (!aresetn) acc_low ##[1:50] acc_high);
  cov_ret_c: cover property (@(posedge aclk) disable iff (!aresetn) ret_low);
  cov_compat_c: cover property (@(posedge aclk) disable iff (!aresetn) !pme && acc_high);
  cov_pin_c: cover property (@(posedge aclk) disable iff (!aresetn) pin_pend ##[1:8] accept);

endmodule

/* hw/irq_ctrl_pkg.sv */
// Shared constants and carrier types for the two-level interrupt controller
package irq_ctrl_pkg;

  // Register byte offsets on the register bus
  localparam logic [3:0] global_irq_control_off    = 4'h0;
  localparam logic [3:0] edge_priority_control_off = 4'h4;
  localparam logic [3:0] ext_pin_irq_control_off   = 4'h8;
  localparam logic [3:0] mode_control_off          = 4'hc;
  localparam logic [3:0] core_status_off           = 4'h0;

  // Reset values
  localparam logic [7:0] global_irq_control_rst    = 8'h00;
  localparam logic [7:0] edge_priority_control_rst = 8'hff;
  localparam logic [7:0] ext_pin_irq_control_rst   = 8'hc0;

  // Vector addresses (21-bit program counter)
  localparam logic [20:0] high_vector = 21'h000008;
  localparam logic [20:0] low_vector  = 21'h000018;

  // Global control field positions
  localparam int glb_en_bit = 7;
  localparam int grp_en_bit = 6;
  localparam int t0ie_bit  = 5;
  localparam int p0ie_bit  = 4;
  localparam int pcie_bit  = 3;
  localparam int t0if_bit  = 2;
  localparam int p0if_bit  = 1;
  localparam int pcif_bit  = 0;
  // Edge/priority control field positions
  localparam int pud_bit   = 7;
  localparam int edg0_bit  = 6;
  localparam int edg1_bit  = 5;
  localparam int edg2_bit  = 4;
  localparam int edg3_bit  = 3;
  localparam int t0ip_bit  = 2;
  localparam int p3ip_bit  = 1;
  localparam int pcip_bit  = 0;
  // Ext pin control field positions
  localparam int p2ip_bit  = 7;
  localparam int p1ip_bit  = 6;
  localparam int p3ie_bit  = 5;
  localparam int p2ie_bit  = 4;
  localparam int p1ie_bit  = 3;
  localparam int p3if_bit  = 2;
  localparam int p2if_bit  = 1;
  localparam int p1if_bit  = 0;

  // Entry delay in clock cycles after pin event sampling
  localparam logic [1:0] entry_delay = 2'h1;

  // Core handshake carrier
  typedef struct packed {
    logic        take;
    logic [20:0] vector;
    logic        high_level;
  } vector_req_type;

endpackage

/* test/core_model.sv */
// Behavioural model of the core fetch logic that faces the interrupt controller
`timescale 1ns/1ns
module core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  vector_req_type   vector_req,
  input  wire logic        push_return,
  input  wire logic [20:0] push_addr,
  output logic             instr_boundary = 1'b1,
  output logic [20:0]      return_addr = 21'h000100,
  output logic             return_from_handler_instr = 1'b0
);
  int          takes = 0;
  logic [20:0] last_vector;
  logic        last_level;
  logic [20:0] last_push;
  logic [20:0] exp_push;

  // Two-cycle instructions hide the boundary on random cycles when slow
  always @(posedge aclk) begin
    instr_boundary <= slow ? 1'($urandom % 2) : 1'b1;
    if (push_return === 1'b1) last_push <= push_addr;
    if (!aresetn) takes <= 0;
    else if (vector_req.take === 1'b1) begin
      takes       <= takes + 1;
      last_vector <= vector_req.vector;
      last_level  <= vector_req.high_level;
      exp_push    <= return_addr;
      return_addr <= 21'($urandom) & 21'h1ffffe; // Next fetch address
    end
  end

  // Handler exit, one cycle pulse
  task automatic leave();
    return_from_handler_instr <= 1'b1;
    @(posedge aclk);
    return_from_handler_instr <= 1'b0;
  endtask
endmodule

/* test/priority_interrupt_controller_tb.sv */
// Self-checking bench for the two-level priority interrupt controller
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module priority_interrupt_controller_tb
  import irq_ctrl_pkg::*;
;
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic           awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic           port_read, timer0_overflow, periph_high_req, periph_low_req, slow, pullup_disable;
  logic           push_return, instr_boundary, return_from_handler_instr;
  logic [3:0]     awaddr, araddr, wstrb, ext_pin_in, upper_port_pins;
  logic [31:0]    wdata, rdata;
  logic [1:0]     bresp, rresp, active_level, rs, bs;
  logic [20:0]    push_addr, return_addr;
  vector_req_type vector_req;
  logic [7:0]     exp_reg [4] = '{8'h00, 8'hff, 8'hc0, 8'h00};
  logic [7:0]     rd, v;
  int             fails, n_tests, cyc, lat, tk;

  priority_interrupt_controller i_priority_interrupt_controller (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ext_pin_in, .upper_port_pins, .port_read,
    .timer0_overflow, .periph_high_req, .periph_low_req, .instr_boundary, .return_addr,
    .return_from_handler_instr, .vector_req, .push_return, .push_addr, .pullup_disable, .active_level
  );
  core_model i_core_model (
    .aclk, .aresetn, .slow, .vector_req, .push_return, .push_addr, .instr_boundary, .return_addr,
    .return_from_handler_instr
  );

  always #20 aclk = ~aclk;

  // Cycle ceiling cuts a hung run short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      results();
    end
  end

  // Register write; address and data released as each is taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bs = bresp;
  endtask

  // Register read into rd and rs
  task automatic rd_reg(input logic [3:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata[7:0]; rs = rresp;
  endtask

  // Waits for the core model to count a new entry, lat cycles at most lim
  task automatic wait_take(input int lim);
    lat = 0;
    while (i_core_model.takes == tk && lat < lim) begin
      @(posedge aclk);
      lat++;
    end
    tk = i_core_model.takes;
  endtask

  task automatic tmr();
    timer0_overflow <= 1'b1;
    @(posedge aclk);
    timer0_overflow <= 1'b0;
  endtask

  task automatic results();
    $display("%0d comparisons, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, port_read, timer0_overflow} = '0;
    {periph_high_req, periph_low_req, slow, awaddr, araddr, ext_pin_in, upper_port_pins, wdata} = '0;
    wstrb = 4'hf;
    v = 8'($urandom(87794));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      rd_reg(4'(i * 4)); `CHK(rd, exp_reg[i])
    end
    `CHK(pullup_disable, 1'b1)
    rd_reg(4'h2); `CHK(rs, 2'h2)
    wr(4'h2, 8'hff); `CHK(bs, 2'h2)
    rd_reg(4'h0); `CHK(rd, 8'h00)
    $display("test reset done");
    // Random edge, pull-up and priority settings read back
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(4'h4, v); `CHK(bs, 2'h0)
      rd_reg(4'h4); `CHK(rd, v)
      `CHK(pullup_disable, v[7])
    end
    wr(4'h4, 8'h00);
    $display("test config done");
    // Events with every enable off; rising edges ignored under falling select
    ext_pin_in <= 4'hf; upper_port_pins <= 4'h5; tmr(); repeat (8) @(posedge aclk);
    rd_reg(4'h0); `CHK(rd, 8'h05)
    rd_reg(4'h8); `CHK(rd, 8'hc0)
    ext_pin_in <= 4'h0; repeat (8) @(posedge aclk);
    rd_reg(4'h0); `CHK(rd, 8'h07)
    rd_reg(4'h8); `CHK(rd, 8'hc7)
    wr(4'h0, 8'h00); rd_reg(4'h0); `CHK(rd, 8'h01)
    port_read <= 1'b1; @(posedge aclk); port_read <= 1'b0;
    wr(4'h0, 8'h00); wr(4'h8, 8'hc0); rd_reg(4'h0); `CHK(rd, 8'h00)
    `CHK(i_core_model.takes, 0)
    $display("test flags done");
    // Compatibility mode, peripheral gated by bit 6, slow core
    slow <= 1'b1; wr(4'h0, 8'h80); periph_high_req <= 1'b1;
    wait_take(30); `CHK(lat, 30)
    wr(4'h0, 8'hc0); wait_take(40);
    `CHK(i_core_model.last_vector, high_vector)
    `CHK(i_core_model.last_push, i_core_model.exp_push)
    periph_high_req <= 1'b0; slow <= 1'b0;
    rd_reg(4'h0); `CHK(rd, 8'h40)
    i_core_model.leave(); rd_reg(4'h0); `CHK(rd, 8'hc0)
    $display("test compat done");
    // Priority mode: low entry, pin 0 preempts, low blocked in high handler
    wr(4'hc, 8'h80); wr(4'h4, 8'h40); wr(4'h0, 8'hf0); tmr(); wait_take(20);
    `CHK(i_core_model.last_vector, low_vector)
    `CHK(i_core_model.last_level, 1'b0)
    `CHK(active_level, 2'b01)
    rd_reg(4'h0); `CHK(rd, 8'hb4)
    ext_pin_in <= 4'h1; wait_take(20);
    `CHK(lat inside {[3:8]}, 1'b1)
    `CHK(i_core_model.last_vector, high_vector)
    `CHK(i_core_model.last_level, 1'b1)
    `CHK(active_level, 2'b11)
    rd_reg(4'h0); `CHK(rd, 8'h36)
    wr(4'h0, 8'hf0); tmr(); wait_take(20); `CHK(lat, 20)
    wr(4'h0, 8'hb0);
    i_core_model.leave(); @(posedge aclk); i_core_model.leave();
    rd_reg(4'h0); `CHK(rd, 8'hf0)
    `CHK(active_level, 2'b00)
    wr(4'h0, 8'h60); periph_low_req <= 1'b1; tmr();
    wait_take(20); `CHK(lat, 20)
    periph_low_req <= 1'b0;
    $display("test priority done");
    results();
  end
endmodule
